// file: hdl/sar_adc_cfg.svh
// Timing and format constants for the SAR converter readout link
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH
`define CLK_PERIOD_NS      10
`define CAL_DELAY_MS       40
`define CAL_TIME_MS        400
`define HOST_WAIT_MS       500
`define HOST_HOT_MS        55
`define CONV_TIME_NS       700
`define CONV_CYCLES        ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_CYCLES(ms)      ((ms) * 1000000 / `CLK_PERIOD_NS)
`define WORD_BITS_HI       14
`define WORD_BITS_LO       12
`define SCLK_HALF_CYCLES   6
`define SYNC_MARGIN_CYCLES 8
`define CNT_W              32
`endif

// file: hdl/sar_adc_pkg.sv
// Types shared by both ends of the converter readout link
package sar_adc_pkg;
    typedef enum logic [2:0] {
        dev_power_wait,
        dev_calibrate,
        acquisition_phase,
        dev_convert
    } dev_state_t;
    typedef enum logic [2:0] {
        host_power_wait,
        host_idle,
        host_start,
        host_wait_conv,
        host_select,
        host_shift,
        host_done
    } host_state_t;
endpackage : sar_adc_pkg

// file: hdl/sar_adc_link_if.sv
// Serial pin bundle between converter and host controller
`timescale 1ns/10ps
interface sar_adc_link_if;
    logic conversion_start_select;
    logic sclk;
    logic sdo;
    logic sdi;
    modport device (input conversion_start_select, input sclk, input sdi, output sdo);
    modport host   (output conversion_start_select, output sclk, output sdi, input sdo);
endinterface : sar_adc_link_if

// file: hdl/sar_adc_device.sv
// Converter end: power-up calibration, conversion timing and serial result
`timescale 1ns/10ps
`include "sar_adc_cfg.svh"
module sar_adc_device
    import sar_adc_pkg::*;
#(
    parameter int        WORD_BITS  = `WORD_BITS_HI,
    parameter int        CAL_DELAY  = `MS_CYCLES(`CAL_DELAY_MS),
    parameter int        CAL_CYCLES = `MS_CYCLES(`CAL_TIME_MS)
) (
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic [15:0]          sample_in,
    input  wire logic                 over_range_in,
    output logic                      ready_out,
    output logic                      converting_out,
    sar_adc_link_if.device            link
);
    localparam logic [15:0] FULL = 16'((32'h1 << WORD_BITS) - 1);

    dev_state_t               state_r;
    logic [`CNT_W-1:0]        cnt_r;
    logic [2:0]               cs_sync_r;
    logic [2:0]               sck_sync_r;
    logic [15:0]              shift_r;
    logic [4:0]               bit_cnt_r;
    logic                     sdo_r;

    // Code clamp: saturate to full scale on over-range, else mask the straight binary code to WORD_BITS
    function automatic logic [15:0] clamp_code(input logic [15:0] s, input logic ovr);
        logic [15:0] c;
        c = s & FULL;
        if (ovr) begin
            c = FULL;
        end
        return c;
    endfunction : clamp_code

    wire cs_rise  = cs_sync_r[1] & ~cs_sync_r[2];
    wire cs_low   = ~cs_sync_r[1];
    wire sck_fall = ~sck_sync_r[1] & sck_sync_r[2];

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cs_sync_r  <= 3'h0;
            sck_sync_r <= 3'h0;
        end else begin
            cs_sync_r  <= {cs_sync_r[1:0], link.conversion_start_select};
            sck_sync_r <= {sck_sync_r[1:0], link.sclk};
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= dev_power_wait;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                dev_power_wait: begin
                    if (cnt_r >= `CNT_W'(CAL_DELAY - 1)) begin
                        state_r <= dev_calibrate;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                dev_calibrate: begin
                    if (cnt_r >= `CNT_W'(CAL_CYCLES - 1)) begin
                        state_r <= acquisition_phase;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                acquisition_phase: begin
                    if (cs_rise) begin
                        state_r <= dev_convert;
                        cnt_r   <= '0;
                    end
                end
                dev_convert: begin
                    if (cnt_r >= `CNT_W'(`CONV_CYCLES - 1)) begin
                        state_r <= acquisition_phase;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: state_r <= dev_power_wait;
            endcase
        end
    end

    // Result capture at conversion end and serial shift on falling SCLK
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_r   <= '0;
            bit_cnt_r <= '0;
            sdo_r     <= 1'b0;
        end else if (state_r == dev_convert && cnt_r >= `CNT_W'(`CONV_CYCLES - 1)) begin
            shift_r   <= clamp_code(sample_in, over_range_in) << (16 - WORD_BITS);
            bit_cnt_r <= '0;
            sdo_r     <= 1'b0;
        end else if (state_r == acquisition_phase && cs_low) begin
            sdo_r <= shift_r[15];
            if (sck_fall && bit_cnt_r < 5'(WORD_BITS)) begin
                shift_r   <= {shift_r[14:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end else begin
            sdo_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ready_out      <= 1'b0;
            converting_out <= 1'b0;
        end else begin
            ready_out      <= (state_r == acquisition_phase);
            converting_out <= (state_r == dev_convert);
        end
    end

    assign link.sdo = sdo_r;
endmodule : sar_adc_device

// file: hdl/sar_adc_host.sv
// Host end: power-up wait, conversion start and serial result readout
`timescale 1ns/10ps
`include "sar_adc_cfg.svh"
module sar_adc_host
    import sar_adc_pkg::*;
#(
    parameter int        WORD_BITS  = `WORD_BITS_HI,
    parameter int        WAIT_CYC   = `MS_CYCLES(`HOST_WAIT_MS + `HOST_HOT_MS)
) (
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 start_in,
    output logic                      busy_out,
    output logic                      valid_out,
    output logic [15:0]               data_out,
    sar_adc_link_if.host              link
);
    host_state_t              state_r;
    logic [`CNT_W-1:0]        cnt_r;
    logic [4:0]               bit_cnt_r;
    logic [15:0]              shift_r;
    logic                     cs_r;
    logic                     sck_r;
    logic [1:0]               sdo_sync_r;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sdo_sync_r <= 2'h0;
        end else begin
            sdo_sync_r <= {sdo_sync_r[0], link.sdo};
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r   <= host_power_wait;
            cnt_r     <= '0;
            bit_cnt_r <= '0;
            shift_r   <= '0;
            cs_r      <= 1'b0;
            sck_r     <= 1'b0;
            valid_out <= 1'b0;
            data_out  <= '0;
        end else begin
            valid_out <= 1'b0;
            unique case (state_r)
                host_power_wait: begin
                    // Lines stay quiet until calibration is surely over
                    if (cnt_r >= `CNT_W'(WAIT_CYC - 1)) begin
                        state_r <= host_idle;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                host_idle: begin
                    if (start_in) begin
                        state_r <= host_start;
                        cs_r    <= 1'b1;
                        cnt_r   <= '0;
                    end
                end
                host_start: begin
                    state_r <= host_wait_conv;
                    cnt_r   <= cnt_r + 1'b1;
                end
                host_wait_conv: begin
                    // Hold select high past conversion time plus sync delay
                    if (cnt_r >= `CNT_W'(`CONV_CYCLES + `SYNC_MARGIN_CYCLES)) begin
                        state_r <= host_select;
                        cs_r    <= 1'b0;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                host_select: begin
                    if (cnt_r >= `CNT_W'(`SCLK_HALF_CYCLES)) begin
                        state_r   <= host_shift;
                        cnt_r     <= '0;
                        bit_cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                host_shift: begin
                    if (cnt_r >= `CNT_W'(`SCLK_HALF_CYCLES - 1)) begin
                        cnt_r <= '0;
                        sck_r <= ~sck_r;
                        // Sample just before the falling edge: the converter moves sdo only after it
                        if (sck_r) begin
                            shift_r   <= {shift_r[14:0], sdo_sync_r[1]};
                            bit_cnt_r <= bit_cnt_r + 1'b1;
                            if (bit_cnt_r == 5'(WORD_BITS - 1)) begin
                                state_r <= host_done;
                            end
                        end
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                host_done: begin
                    valid_out <= 1'b1;
                    data_out  <= shift_r & 16'((32'h1 << WORD_BITS) - 1);
                    cs_r      <= 1'b1;
                    state_r   <= host_idle;
                end
                default: state_r <= host_power_wait;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_out <= 1'b1;
        end else begin
            busy_out <= (state_r != host_idle);
        end
    end

    assign link.conversion_start_select = cs_r;
    assign link.sclk = sck_r;
    assign link.sdi  = 1'b1;
endmodule : sar_adc_host

// file: tb/sar_adc_link_assertions.sv
// Concurrent checks on the converter readout link pins
`timescale 1ns/10ps
module sar_adc_link_assertions #(
    parameter int WORD_BITS  = 14,
    parameter int CAL_DELAY  = 20,
    parameter int CAL_CYCLES = 50,
    parameter int WAIT_CYC   = 100
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic conversion_start_select,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sdi
);
    logic [31:0] age_r;
    logic [7:0]  rises_r;
    logic        sclk_d_r;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            age_r <= 32'h0;
        end else if (age_r != 32'hffffffff) begin
            age_r <= age_r + 32'h1;
        end
    end
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk;
        end
    end
    // Rising SCLK edges seen in the current frame
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rises_r <= 8'h0;
        end else if (conversion_start_select) begin
            rises_r <= 8'h0;
        end else if (sclk && !sclk_d_r) begin
            rises_r <= rises_r + 8'h1;
        end
    end
    sdi_held_high_a: assert property (sdi)
        else $error("sdi left its high level");
    sdo_deselect_quiet_a: assert property (conversion_start_select [*4] |-> !sdo)
        else $error("sdo active while not selected");
    sclk_in_frame_a: assert property ($changed(sclk) |-> !conversion_start_select)
        else $error("sclk toggled outside a frame");
    sdo_steady_high_a: assert property (sclk [*4] |-> $stable(sdo))
        else $error("sdo moved while sclk high");
    sclk_half_period_a: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
        else $error("sclk high phase not six cycles");
    frame_hold_a: assert property ($fell(conversion_start_select) |=> !conversion_start_select [*8])
        else $error("frame released too early");
    frame_bit_count_a: assert property ($rose(conversion_start_select) && rises_r != 8'h0
        |-> rises_r == 8'(WORD_BITS))
        else $error("frame bit count wrong");
    cal_sdo_quiet_a: assert property (age_r < 32'(CAL_DELAY + CAL_CYCLES) |-> !sdo)
        else $error("sdo active during calibration");
    host_wait_quiet_a: assert property (age_r < 32'(WAIT_CYC) |-> !conversion_start_select && !sclk)
        else $error("host active before its wait ended");
endmodule : sar_adc_link_assertions

// file: tb/sar_adc_conversion_readout_tb.sv
// Self-checking bench joining converter and host ends over the serial link
`timescale 1ns/10ps
module sar_adc_conversion_readout_tb import sar_adc_pkg::*; ;
    localparam int          WB   = 14;
    localparam int          CD   = 20;
    localparam int          CC   = 50;
    localparam int          WC   = 100;
    localparam logic [15:0] FULL = (16'h1 << WB) - 16'h1;
    logic        sys_clk_in    = 1'b0;
    logic        reset_n_in    = 1'b0;
    logic [15:0] sample_in     = 16'h0;
    logic        over_range_in = 1'b0;
    logic        start_in      = 1'b0;
    logic        ready_out;
    logic        converting_out;
    logic        busy_out;
    logic        valid_out;
    logic [15:0] data_out;
    logic [15:0] wire_word_r   = 16'h0;
    logic        sclk_d_r      = 1'b0;
    logic        cs_d_r        = 1'b0;
    int          n_errors      = 0;
    int          cmp_count     = 0;
    sar_adc_link_if u_sar_adc_link_if ();
    sar_adc_device #(.WORD_BITS(WB), .CAL_DELAY(CD), .CAL_CYCLES(CC)) u_sar_adc_device (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .sample_in(sample_in),
        .over_range_in(over_range_in), .ready_out(ready_out), .converting_out(converting_out),
        .link(u_sar_adc_link_if));
    sar_adc_host #(.WORD_BITS(WB), .WAIT_CYC(WC)) u_sar_adc_host (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .start_in(start_in), .busy_out(busy_out),
        .valid_out(valid_out), .data_out(data_out), .link(u_sar_adc_link_if));
    sar_adc_link_assertions #(.WORD_BITS(WB), .CAL_DELAY(CD), .CAL_CYCLES(CC), .WAIT_CYC(WC))
        u_sar_adc_link_assertions (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .conversion_start_select(u_sar_adc_link_if.conversion_start_select),
        .sclk(u_sar_adc_link_if.sclk), .sdo(u_sar_adc_link_if.sdo), .sdi(u_sar_adc_link_if.sdi));
    always #5 sys_clk_in = ~sys_clk_in;
    // Independent capture of the word on the wire at each rising SCLK
    always @(posedge sys_clk_in) begin
        sclk_d_r <= u_sar_adc_link_if.sclk;
        cs_d_r <= u_sar_adc_link_if.conversion_start_select;
        if (cs_d_r && !u_sar_adc_link_if.conversion_start_select) begin
            wire_word_r <= 16'h0;
        end else if (!sclk_d_r && u_sar_adc_link_if.sclk && !u_sar_adc_link_if.conversion_start_select) begin
            wire_word_r <= {wire_word_r[14:0], u_sar_adc_link_if.sdo};
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic wait_lvl(input string what, ref logic sig, input logic lvl, input int limit);
        for (int i = 0; i < limit && sig !== lvl; i++) @(posedge sys_clk_in);
        if (sig !== lvl) begin
            n_errors++;
            $display("mismatch %s expected %b seen timeout", what, lvl);
            conclude();
        end
    endtask : wait_lvl
    task automatic convert(input logic [15:0] smp, input logic ovr, input logic [15:0] exp);
        wait_lvl("host_idle", busy_out, 1'b0, 60);
        sample_in <= smp;
        over_range_in <= ovr;
        start_in <= 1'b1;
        wait_lvl("host_busy", busy_out, 1'b1, 10);
        start_in <= 1'b0;
        wait_lvl("converting", converting_out, 1'b1, 20);
        check("ready_in_conv", {15'h0, ready_out}, 16'h0);
        wait_lvl("valid", valid_out, 1'b1, 400);
        check("data_out", data_out, exp);
        check("wire_word", wire_word_r, exp);
        check("ready_after", {15'h0, ready_out}, 16'h1);
    endtask : convert
    initial begin
        repeat (16) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        repeat (30) @(posedge sys_clk_in);
        start_in <= 1'b1;
        @(posedge sys_clk_in);
        start_in <= 1'b0;
        check("busy_wait", {15'h0, busy_out}, 16'h1);
        repeat (CD + CC - 36) @(posedge sys_clk_in);
        check("ready_cal", {15'h0, ready_out}, 16'h0);
        check("sdo_cal", {15'h0, u_sar_adc_link_if.sdo}, 16'h0);
        repeat (10) @(posedge sys_clk_in);
        check("ready_done", {15'h0, ready_out}, 16'h1);
        convert(16'h2a5c, 1'b0, 16'h2a5c & FULL);
        convert(16'hffff, 1'b0, FULL);
        convert(16'h0000, 1'b0, 16'h0000);
        convert(16'h1555, 1'b1, FULL);
        convert(16'h2001, 1'b0, 16'h2001 & FULL);
        conclude();
    end
endmodule : sar_adc_conversion_readout_tb
